// >>> inc/adcism_pkg.sv
// Purpose: Shared constants and types for input select and amp monitor
// Assumes: One clock, hclk, at 100 MHz
// Notes:   Device offsets are 8-bit link addresses
package adcism_pkg;
  // Device register map on the link
  localparam logic [7:0] DEV_PRI_STAT = 8'h01;
  localparam logic [7:0] DEV_CMD      = 8'h08;
  localparam logic [7:0] DEV_IN_CFG   = 8'h10;
  localparam logic [7:0] DEV_AMP_FLG  = 8'h11;
  localparam logic [7:0] DEV_SEC_FLG  = 8'h12;
  localparam logic [7:0] DEV_AMP_CFG  = 8'h20;
  // Field positions
  localparam int SUM_BIT   = 4;
  localparam int CRC_BIT   = 0;
  localparam int START_BIT = 0;
  localparam int AZ_BIT    = 4;
  // Selector codes
  localparam logic [2:0] SEL_B_A   = 3'h0;
  localparam logic [2:0] SEL_A_B   = 3'h1;
  localparam logic [2:0] SEL_B_COM = 3'h2;
  localparam logic [2:0] SEL_A_COM = 3'h3;
  localparam logic [2:0] SEL_HV    = 3'h4;
  localparam logic [2:0] SEL_MID   = 3'h5;
  localparam logic [2:0] SEL_TEMP  = 3'h6;
  localparam logic [2:0] SEL_RSVD  = 3'h7;
  // Reset values and the unity gain code
  localparam logic [2:0] SEL_RESET  = SEL_MID;
  localparam logic [3:0] GAIN_UNITY = 4'h4;
  localparam logic [3:0] GAIN_RESET = 4'h4;
  localparam logic       AZ_RESET   = 1'b0;
  // Host AHB register map
  localparam logic [7:0] H_LADDR  = 8'h00;
  localparam logic [7:0] H_LWDATA = 8'h04;
  localparam logic [7:0] H_CMD    = 8'h08;
  localparam logic [7:0] H_LRDATA = 8'h0C;
  localparam logic [7:0] H_STAT   = 8'h10;
  localparam logic [7:0] H_CTRL   = 8'h14;
  localparam logic [7:0] H_IRQ_ST = 8'h18;
  localparam logic [7:0] H_IRQ_CL = 8'h1C;
  localparam logic [7:0] H_IRQ_EN = 8'h20;
  // Host command and irq bits
  localparam int CMD_RD   = 0;
  localparam int CMD_WR   = 1;
  localparam int CMD_SEL  = 2;
  localparam int CMD_CODE = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ALM  = 1;
  localparam int IRQ_BAD  = 2;

  // Measurement source on each amplifier input
  typedef enum logic [2:0] {
    SRC_NONE = 3'b000,
    SRC_A    = 3'b001,
    SRC_B    = 3'b010,
    SRC_COM  = 3'b011,
    SRC_MID  = 3'b100,
    SRC_TEMP = 3'b101,
    SRC_HV   = 3'b110
  } adcism_src_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_USER  = 3'b001,
    HS_GAIN  = 3'b010,
    HS_MUX   = 3'b011,
    HS_START = 3'b100,
    HS_POLL  = 3'b101,
    HS_RD11  = 3'b110,
    HS_RD12  = 3'b111
  } adcism_hstate_t;
endpackage : adcism_pkg

// >>> inc/adcism_link_if.sv
// Purpose: Register link between host controller and converter device
// Assumes: Both ends on hclk; req is a level, ack a one-cycle pulse
// Notes:   Host holds req and fields until it samples ack
`timescale 1ns/1ps
interface adcism_link_if;
  logic       req;
  logic       wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;

  modport host (output req, output wr, output addr, output wdata,
                input ack, input rdata);
  modport dev  (input req, input wr, input addr, input wdata,
                output ack, output rdata);
endinterface : adcism_link_if

// >>> verilog/adcism_dev.sv
// Purpose: Converter device input selector, amp mode and alarm latches
// Assumes: Alarm and error inputs synchronous to hclk
// Notes:   Routing changes only at a conversion start
// Summary of operation
// - Three-bit selector at register 10h
// - Codes 000/001 route B-A, A-B
// - Codes 010/011 route B, A against common
// - Code 100 measures high rail /36
// - Host sets unity gain before rail readback
// - Code 101 default, mid-rail input short
// - Code 110 selects temperature sensor
// - Host keeps unity gain, no auto-zero
// - Gain code picks gain or attenuation
// - Eight alarms reported individually at 11h
// - Summary bit 4 ORs alarms, link error
// - Alarm bits stay latched after condition
// - Reading 11h clears alarm bits
// - Summary clears after both sources clear
// - Host reads 11h, 12h after summary
// - Brief overload still sets alarm bit
`timescale 1ns/1ps
module adcism_dev (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  adcism_link_if.dev       lk,
  input  wire logic [7:0]  alarm_in,
  input  wire logic        crc_err_in,
  input  wire logic        start_in,
  output logic             conv_start_ff,
  output adcism_pkg::adcism_src_t pos_src_ff,
  output adcism_pkg::adcism_src_t neg_src_ff,
  output logic             hv_div_en_ff,
  output logic [3:0]       gain_code_ff,
  output logic             gain_mode_ff,
  output logic             autozero_ff,
  output logic             summary_flag
);
  logic       ack_ff;
  logic [7:0] rdata_ff;
  logic       acc;
  logic       acc_wr;
  logic       acc_rd;
  logic [2:0] sel_ff;
  logic [7:0] amp_flg_ff;
  logic       crc_flg_ff;
  logic [7:0] nxt_amp_flg;
  logic       nxt_crc_flg;
  logic       start_p;
  logic [7:0] rd_mux;
  adcism_pkg::adcism_src_t nxt_pos;
  adcism_pkg::adcism_src_t nxt_neg;

  // One transfer per request; ack low again before next
  assign acc    = lk.req & ~ack_ff;
  assign acc_wr = acc & lk.wr;
  assign acc_rd = acc & ~lk.wr;
  assign lk.ack   = ack_ff;
  assign lk.rdata = rdata_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ack_ff <= 1'b0;
    else
      ack_ff <= acc;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rdata_ff <= 8'h00;
    else if (acc_rd)
      rdata_ff <= rd_mux;
  end

  assign summary_flag = (|amp_flg_ff) | crc_flg_ff;

  always_comb
  begin
    rd_mux = 8'h00;
    case (lk.addr)
      adcism_pkg::DEV_PRI_STAT:
        rd_mux[adcism_pkg::SUM_BIT] = summary_flag;
      adcism_pkg::DEV_IN_CFG:
        rd_mux[2:0] = sel_ff;
      adcism_pkg::DEV_AMP_FLG:
        rd_mux = amp_flg_ff;
      adcism_pkg::DEV_SEC_FLG:
        rd_mux[adcism_pkg::CRC_BIT] = crc_flg_ff;
      adcism_pkg::DEV_AMP_CFG:
      begin
        rd_mux[3:0] = gain_code_ff;
        rd_mux[adcism_pkg::AZ_BIT] = autozero_ff;
      end
      default:
        rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_ff <= adcism_pkg::SEL_RESET;
    else if (acc_wr && lk.addr == adcism_pkg::DEV_IN_CFG)
      sel_ff <= lk.wdata[2:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gain_code_ff <= adcism_pkg::GAIN_RESET;
      autozero_ff  <= adcism_pkg::AZ_RESET;
    end
    else if (acc_wr && lk.addr == adcism_pkg::DEV_AMP_CFG)
    begin
      gain_code_ff <= lk.wdata[3:0];
      autozero_ff  <= lk.wdata[adcism_pkg::AZ_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gain_mode_ff <= 1'b1;
    else
      gain_mode_ff <= (gain_code_ff >= adcism_pkg::GAIN_UNITY);
  end

  assign start_p = start_in |
                   (acc_wr && lk.addr == adcism_pkg::DEV_CMD &&
                    lk.wdata[adcism_pkg::START_BIT]);

  always_comb
  begin
    nxt_pos = adcism_pkg::SRC_NONE;
    nxt_neg = adcism_pkg::SRC_NONE;
    case (sel_ff)
      adcism_pkg::SEL_B_A:
      begin
        nxt_pos = adcism_pkg::SRC_B;
        nxt_neg = adcism_pkg::SRC_A;
      end
      adcism_pkg::SEL_A_B:
      begin
        nxt_pos = adcism_pkg::SRC_A;
        nxt_neg = adcism_pkg::SRC_B;
      end
      adcism_pkg::SEL_B_COM:
      begin
        nxt_pos = adcism_pkg::SRC_B;
        nxt_neg = adcism_pkg::SRC_COM;
      end
      adcism_pkg::SEL_A_COM:
      begin
        nxt_pos = adcism_pkg::SRC_A;
        nxt_neg = adcism_pkg::SRC_COM;
      end
      adcism_pkg::SEL_HV:
      begin
        nxt_pos = adcism_pkg::SRC_HV;
        nxt_neg = adcism_pkg::SRC_HV;
      end
      adcism_pkg::SEL_MID:
      begin
        nxt_pos = adcism_pkg::SRC_MID;
        nxt_neg = adcism_pkg::SRC_MID;
      end
      adcism_pkg::SEL_TEMP:
      begin
        nxt_pos = adcism_pkg::SRC_TEMP;
        nxt_neg = adcism_pkg::SRC_TEMP;
      end
      // Reserved code leaves both inputs open
      default:
      begin
        nxt_pos = adcism_pkg::SRC_NONE;
        nxt_neg = adcism_pkg::SRC_NONE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pos_src_ff   <= adcism_pkg::SRC_MID;
      neg_src_ff   <= adcism_pkg::SRC_MID;
      hv_div_en_ff <= 1'b0;
    end
    else if (start_p)
    begin
      pos_src_ff   <= nxt_pos;
      neg_src_ff   <= nxt_neg;
      hv_div_en_ff <= (sel_ff == adcism_pkg::SEL_HV);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      conv_start_ff <= 1'b0;
    else
      conv_start_ff <= start_p;
  end

  always_comb
  begin
    nxt_amp_flg = amp_flg_ff;
    if (acc_rd && lk.addr == adcism_pkg::DEV_AMP_FLG)
      nxt_amp_flg = 8'h00;
    nxt_amp_flg = nxt_amp_flg | alarm_in;
  end

  // Link error clears on read of its own register
  always_comb
  begin
    nxt_crc_flg = crc_flg_ff;
    if (acc_rd && lk.addr == adcism_pkg::DEV_SEC_FLG)
      nxt_crc_flg = 1'b0;
    nxt_crc_flg = nxt_crc_flg | crc_err_in;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      amp_flg_ff <= 8'h00;
      crc_flg_ff <= 1'b0;
    end
    else
    begin
      amp_flg_ff <= nxt_amp_flg;
      crc_flg_ff <= nxt_crc_flg;
    end
  end
endmodule : adcism_dev

// >>> verilog/adcism_host.sv
// Purpose: Host controller: AHB-Lite registers, link master, poller
// Assumes: Zero-wait AHB slave, single word transfers
// Notes:   Source select sequences unity gain for rail and sensor
`timescale 1ns/1ps
module adcism_host (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             irq,
  adcism_link_if.host      lk
);
  adcism_pkg::adcism_hstate_t state_ff;
  adcism_pkg::adcism_hstate_t nxt_state;
  logic       dp_wr_ff;
  logic [7:0] dp_addr_ff;
  logic [7:0] laddr_ff;
  logic [7:0] lwdata_ff;
  logic [7:0] lrdata_ff;
  logic       user_wr_ff;
  logic [2:0] code_ff;
  logic       poll_en_ff;
  logic [7:0] amp_cap_ff;
  logic [7:0] sec_cap_ff;
  logic [2:0] irq_st_ff;
  logic [2:0] irq_en_ff;
  logic [2:0] irq_set;
  logic       we;
  logic       cmd_ok;
  logic       bad;
  logic [2:0] wcode;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign we        = dp_wr_ff;
  assign wcode     = hwdata[adcism_pkg::CMD_CODE +: 3];
  assign cmd_ok    = we && dp_addr_ff == adcism_pkg::H_CMD &&
                     state_ff == adcism_pkg::HS_IDLE;
  assign bad = cmd_ok && hwdata[adcism_pkg::CMD_SEL] &&
               !hwdata[adcism_pkg::CMD_RD] && !hwdata[adcism_pkg::CMD_WR] &&
               wcode == adcism_pkg::SEL_RSVD;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_ff   <= 1'b0;
      dp_addr_ff <= 8'h00;
    end
    else if (hready)
    begin
      dp_wr_ff   <= hsel & htrans[1] & hwrite;
      dp_addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      laddr_ff   <= 8'h00;
      lwdata_ff  <= 8'h00;
      poll_en_ff <= 1'b0;
      irq_en_ff  <= 3'h0;
    end
    else if (we)
    begin
      if (dp_addr_ff == adcism_pkg::H_LADDR)
        laddr_ff <= hwdata[7:0];
      if (dp_addr_ff == adcism_pkg::H_LWDATA)
        lwdata_ff <= hwdata[7:0];
      if (dp_addr_ff == adcism_pkg::H_CTRL)
        poll_en_ff <= hwdata[0];
      if (dp_addr_ff == adcism_pkg::H_IRQ_EN)
        irq_en_ff <= hwdata[2:0];
    end
  end

  always_comb
  begin
    hrdata = 32'h0000_0000;
    case (dp_addr_ff)
      adcism_pkg::H_LADDR:  hrdata[7:0] = laddr_ff;
      adcism_pkg::H_LWDATA: hrdata[7:0] = lwdata_ff;
      adcism_pkg::H_LRDATA: hrdata[7:0] = lrdata_ff;
      adcism_pkg::H_STAT:
        hrdata = {8'h00, sec_cap_ff, amp_cap_ff, 7'h00,
                  state_ff != adcism_pkg::HS_IDLE};
      adcism_pkg::H_CTRL:   hrdata[0]   = poll_en_ff;
      adcism_pkg::H_IRQ_ST: hrdata[2:0] = irq_st_ff;
      adcism_pkg::H_IRQ_EN: hrdata[2:0] = irq_en_ff;
      default:              hrdata = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      adcism_pkg::HS_IDLE:
        if (cmd_ok && (hwdata[adcism_pkg::CMD_RD] || hwdata[adcism_pkg::CMD_WR]))
          nxt_state = adcism_pkg::HS_USER;
        else if (cmd_ok && hwdata[adcism_pkg::CMD_SEL] && !bad)
          nxt_state = (wcode == adcism_pkg::SEL_HV || wcode == adcism_pkg::SEL_TEMP) ?
                      adcism_pkg::HS_GAIN : adcism_pkg::HS_MUX;
        else if (poll_en_ff && !cmd_ok)
          nxt_state = adcism_pkg::HS_POLL;
      adcism_pkg::HS_USER:  if (lk.ack) nxt_state = adcism_pkg::HS_IDLE;
      adcism_pkg::HS_GAIN:  if (lk.ack) nxt_state = adcism_pkg::HS_MUX;
      adcism_pkg::HS_MUX:   if (lk.ack) nxt_state = adcism_pkg::HS_START;
      adcism_pkg::HS_START: if (lk.ack) nxt_state = adcism_pkg::HS_IDLE;
      adcism_pkg::HS_POLL:
        if (lk.ack)
          nxt_state = lk.rdata[adcism_pkg::SUM_BIT] ?
                      adcism_pkg::HS_RD11 : adcism_pkg::HS_IDLE;
      adcism_pkg::HS_RD11:  if (lk.ack) nxt_state = adcism_pkg::HS_RD12;
      adcism_pkg::HS_RD12:  if (lk.ack) nxt_state = adcism_pkg::HS_IDLE;
      default:              nxt_state = adcism_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_ff <= adcism_pkg::HS_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      user_wr_ff <= 1'b0;
      code_ff    <= adcism_pkg::SEL_RESET;
    end
    else if (cmd_ok)
    begin
      user_wr_ff <= hwdata[adcism_pkg::CMD_WR] & ~hwdata[adcism_pkg::CMD_RD];
      code_ff    <= wcode;
    end
  end

  // Link request follows state; fields held until ack
  always_comb
  begin
    lk.req   = 1'b1;
    lk.wr    = 1'b0;
    lk.addr  = 8'h00;
    lk.wdata = 8'h00;
    case (state_ff)
      adcism_pkg::HS_USER:
      begin
        lk.wr    = user_wr_ff;
        lk.addr  = laddr_ff;
        lk.wdata = lwdata_ff;
      end
      adcism_pkg::HS_GAIN:
      begin
        lk.wr    = 1'b1;
        lk.addr  = adcism_pkg::DEV_AMP_CFG;
        lk.wdata = {4'h0, adcism_pkg::GAIN_UNITY};
      end
      adcism_pkg::HS_MUX:
      begin
        lk.wr    = 1'b1;
        lk.addr  = adcism_pkg::DEV_IN_CFG;
        lk.wdata = {5'h00, code_ff};
      end
      adcism_pkg::HS_START:
      begin
        lk.wr    = 1'b1;
        lk.addr  = adcism_pkg::DEV_CMD;
        lk.wdata = 8'h01;
      end
      adcism_pkg::HS_POLL: lk.addr = adcism_pkg::DEV_PRI_STAT;
      adcism_pkg::HS_RD11: lk.addr = adcism_pkg::DEV_AMP_FLG;
      adcism_pkg::HS_RD12: lk.addr = adcism_pkg::DEV_SEC_FLG;
      default:             lk.req  = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lrdata_ff  <= 8'h00;
      amp_cap_ff <= 8'h00;
      sec_cap_ff <= 8'h00;
    end
    else if (lk.ack)
    begin
      if (state_ff == adcism_pkg::HS_USER && !user_wr_ff)
        lrdata_ff <= lk.rdata;
      if (state_ff == adcism_pkg::HS_RD11)
        amp_cap_ff <= lk.rdata;
      if (state_ff == adcism_pkg::HS_RD12)
        sec_cap_ff <= lk.rdata;
    end
  end

  always_comb
  begin
    irq_set = 3'h0;
    irq_set[adcism_pkg::IRQ_DONE] = lk.ack &&
      (state_ff == adcism_pkg::HS_USER || state_ff == adcism_pkg::HS_START);
    irq_set[adcism_pkg::IRQ_ALM] = lk.ack && state_ff == adcism_pkg::HS_RD12;
    irq_set[adcism_pkg::IRQ_BAD] = bad;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_st_ff <= 3'h0;
    else if (we && dp_addr_ff == adcism_pkg::H_IRQ_CL)
      irq_st_ff <= (irq_st_ff & ~hwdata[2:0]) | irq_set;
    else
      irq_st_ff <= irq_st_ff | irq_set;
  end

  assign irq = |(irq_st_ff & irq_en_ff);
endmodule : adcism_host

// >>> testbench/adcism_asserts.sv
// Purpose: Link protocol and host sequencing checks
// Assumes: Sees only the link between the two ends
// Notes:   Shadows selector and gain writes seen on the link
`timescale 1ns/1ps
module adcism_asserts (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       req,
  input wire logic       wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata
);
  logic       take;
  logic [2:0] sel_ff;
  logic [7:0] gain_ff;
  assign take = req && !ack;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sel_ff <= adcism_pkg::SEL_RESET;
    else if (take && wr && addr == adcism_pkg::DEV_IN_CFG)
      sel_ff <= wdata[2:0];
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gain_ff <= {3'h0, adcism_pkg::AZ_RESET, adcism_pkg::GAIN_RESET};
    else if (take && wr && addr == adcism_pkg::DEV_AMP_CFG)
      gain_ff <= wdata;
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  chk_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack wider than one cycle");
  chk_ack_after_take: assert property (take |=> ack)
    else $error("ack missing after request");
  chk_ack_needs_req: assert property (ack |-> $past(req))
    else $error("ack without request");
  chk_req_held: assert property (take |=> req && $stable(wr) && $stable(addr) && $stable(wdata))
    else $error("request dropped before ack");
  chk_rdata_holds: assert property (!(take && !wr) |=> $stable(rdata))
    else $error("read data moved without a read");
  chk_sel_readback: assert property (
    ack && !wr && addr == adcism_pkg::DEV_IN_CFG |-> rdata[2:0] == sel_ff)
    else $error("selector readback differs");
  // Unity gain, auto-zero off
  chk_gain_before_src: assert property (
    take && wr && addr == adcism_pkg::DEV_IN_CFG
    && (wdata[2:0] == adcism_pkg::SEL_HV || wdata[2:0] == adcism_pkg::SEL_TEMP)
    |-> gain_ff == 8'h04)
    else $error("rail or sensor selected without unity gain");
  chk_no_rsvd_code: assert property (
    take && wr && addr == adcism_pkg::DEV_IN_CFG |-> wdata[2:0] != adcism_pkg::SEL_RSVD)
    else $error("reserved selector code written");
  chk_poll_follows: assert property (
    ack && !wr && addr == adcism_pkg::DEV_PRI_STAT && rdata[adcism_pkg::SUM_BIT]
    |-> ##[1:4] (req && !wr && addr == adcism_pkg::DEV_AMP_FLG))
    else $error("summary seen but alarm flags not read");
  cover property (ack && !wr && addr == adcism_pkg::DEV_AMP_FLG && rdata != 8'h00);
  cover property (take && wr && addr == adcism_pkg::DEV_IN_CFG && wdata[2:0] == 3'h4);
  cover property (ack && !wr && addr == adcism_pkg::DEV_PRI_STAT && rdata[4]);
endmodule : adcism_asserts

// >>> testbench/testbench.sv
// Purpose: Host and device joined over the link, driven through AHB-Lite
// Assumes: Poll stays off unless the interrupt scenario runs
// Notes:   Expectations come from bench functions, package constants and literals
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    checks_done++; \
    if ((gt) !== (ex)) \
    begin \
      fail_count++; \
      $display("mismatch %s expected %0h seen %0h", nm, ex, gt); \
    end \
  end
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [2:0]  hsize, c, d;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0]  alarm_in, m;
  logic        crc_err_in, start_in, conv_start_ff, hv_div_en_ff, gain_mode_ff;
  logic        autozero_ff, summary_flag;
  logic [3:0]  gain_code_ff, g;
  int          fail_count, checks_done, base, n;
  adcism_pkg::adcism_src_t pos_src_ff, neg_src_ff;
  adcism_link_if lk ();
  assign hready = hreadyout;
  adcism_host i_adcism_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .lk(lk));
  adcism_dev i_adcism_dev (.hclk(hclk), .hresetn(hresetn), .lk(lk), .alarm_in(alarm_in),
    .crc_err_in(crc_err_in), .start_in(start_in), .conv_start_ff(conv_start_ff),
    .pos_src_ff(pos_src_ff), .neg_src_ff(neg_src_ff), .hv_div_en_ff(hv_div_en_ff),
    .gain_code_ff(gain_code_ff), .gain_mode_ff(gain_mode_ff), .autozero_ff(autozero_ff),
    .summary_flag(summary_flag));
  adcism_asserts i_adcism_asserts (.hclk(hclk), .hresetn(hresetn), .req(lk.req), .wr(lk.wr),
    .addr(lk.addr), .wdata(lk.wdata), .ack(lk.ack), .rdata(lk.rdata));
  always #5 hclk = ~hclk;
  function automatic adcism_pkg::adcism_src_t exp_pos(input logic [2:0] s);
    adcism_pkg::adcism_src_t t [8] = '{adcism_pkg::SRC_B, adcism_pkg::SRC_A, adcism_pkg::SRC_B,
      adcism_pkg::SRC_A, adcism_pkg::SRC_HV, adcism_pkg::SRC_MID, adcism_pkg::SRC_TEMP,
      adcism_pkg::SRC_NONE};
    return t[s];
  endfunction : exp_pos
  function automatic adcism_pkg::adcism_src_t exp_neg(input logic [2:0] s);
    adcism_pkg::adcism_src_t t [8] = '{adcism_pkg::SRC_A, adcism_pkg::SRC_B, adcism_pkg::SRC_COM,
      adcism_pkg::SRC_COM, adcism_pkg::SRC_HV, adcism_pkg::SRC_MID, adcism_pkg::SRC_TEMP,
      adcism_pkg::SRC_NONE};
    return t[s];
  endfunction : exp_neg
  task automatic close_out;
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, 24'h0, a, w};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  // Busy wait bounded; a stuck command shows as a mismatch
  task automatic cmd(input logic [31:0] cw);
    int k;
    ahb(1'b1, adcism_pkg::H_CMD, cw);
    k = 0;
    do ahb(1'b0, adcism_pkg::H_STAT, 32'h0); while (q[0] === 1'b1 && ++k < 60);
    `CHK("busy", 1'b0, q[0]);
  endtask : cmd
  task automatic lrd(input logic [7:0] a);
    ahb(1'b1, adcism_pkg::H_LADDR, {24'h0, a});
    cmd(32'h1);
    ahb(1'b0, adcism_pkg::H_LRDATA, 32'h0);
  endtask : lrd
  task automatic lwr(input logic [7:0] a, input logic [7:0] wd);
    ahb(1'b1, adcism_pkg::H_LADDR, {24'h0, a});
    ahb(1'b1, adcism_pkg::H_LWDATA, {24'h0, wd});
    cmd(32'h2);
  endtask : lwr
  task automatic pulse(input logic [7:0] a, input logic e, input logic s);
    @(posedge hclk);
    {alarm_in, crc_err_in, start_in} <= {a, e, s};
    @(posedge hclk);
    {alarm_in, crc_err_in, start_in} <= 10'h0;
    #1;
    if (s)
      `CHK("conv_start", 1'b1, conv_start_ff);
    repeat (2) @(posedge hclk);
    #1;
  endtask : pulse
  initial
  begin
    repeat (50000) @(posedge hclk);
    fail_count++;
    close_out();
  end
  initial
  begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {alarm_in, crc_err_in, start_in, fail_count, checks_done} = '0;
    hsize = 3'h2;
    void'($urandom(32'h349F9BFA));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    `CHK("rst_src", {2{adcism_pkg::SRC_MID}}, {pos_src_ff, neg_src_ff});
    `CHK("rst_gain", {adcism_pkg::GAIN_RESET, 1'b1}, {gain_code_ff, gain_mode_ff});
    `CHK("rst_flags", 4'h0, {autozero_ff, summary_flag, irq, hresp});
    lrd(adcism_pkg::DEV_IN_CFG);
    `CHK("sel_rst", adcism_pkg::SEL_RESET, q[2:0]);
    lrd(8'h3F);
    `CHK("unmapped", 32'h0, q);
    base = $urandom_range(6, 0);
    for (int i = 0; i < 7; i++)
    begin
      c = 3'((base + i) % 7);
      // Non-unity gain, auto-zero on: the host must rewrite both
      lwr(adcism_pkg::DEV_AMP_CFG, {3'h0, 1'b1, 4'($urandom_range(11, 5))});
      cmd((32'h1 << adcism_pkg::CMD_SEL) | ({29'h0, c} << adcism_pkg::CMD_CODE));
      pulse(8'h00, 1'b0, 1'b1);
      `CHK("pos_src", exp_pos(c), pos_src_ff);
      `CHK("neg_src", exp_neg(c), neg_src_ff);
      `CHK("hv_div", c == 3'h4, hv_div_en_ff);
      if (c == 3'h4 || c == 3'h6)
      begin
        `CHK("unity", adcism_pkg::GAIN_UNITY, gain_code_ff);
        `CHK("az_off", 1'b0, autozero_ff);
      end
    end
    // Distinct code, so the held routing is told apart
    d = 3'($urandom_range(3, 0));
    if (d == c)
      d = d ^ 3'h1;
    lwr(adcism_pkg::DEV_IN_CFG, {5'h0, d});
    `CHK("sel_hold", {exp_pos(c), exp_neg(c)}, {pos_src_ff, neg_src_ff});
    pulse(8'h00, 1'b0, 1'b1);
    `CHK("sel_next", {exp_pos(d), exp_neg(d)}, {pos_src_ff, neg_src_ff});
    for (int i = 0; i < 5; i++)
    begin
      g = (i < 2) ? 4'(3 + i) : 4'($urandom_range(11, 0));
      lwr(adcism_pkg::DEV_AMP_CFG, {3'h0, i == 4, g});
      `CHK("gain_code", {g, i == 4}, {gain_code_ff, autozero_ff});
      `CHK("gain_mode", g >= 4'h4, gain_mode_ff);
    end
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i, 1'b0, 1'b0);
      `CHK("summary_set", 1'b1, summary_flag);
      lrd(adcism_pkg::DEV_AMP_FLG);
      `CHK("amp_flags", 8'h01 << i, q[7:0]);
      `CHK("summary_clr", 1'b0, summary_flag);
    end
    m = 8'($urandom_range(255, 1));
    pulse(m, 1'b1, 1'b0);
    lwr(adcism_pkg::DEV_AMP_FLG, 8'h00);
    lrd(adcism_pkg::DEV_AMP_FLG);
    `CHK("amp_multi", m, q[7:0]);
    `CHK("summary_crc", 1'b1, summary_flag);
    lrd(adcism_pkg::DEV_AMP_FLG);
    `CHK("amp_reread", 8'h00, q[7:0]);
    lrd(adcism_pkg::DEV_SEC_FLG);
    `CHK("crc_flag", 1'b1, q[adcism_pkg::CRC_BIT]);
    `CHK("summary_off", 1'b0, summary_flag);
    ahb(1'b1, adcism_pkg::H_IRQ_CL, 32'h7);
    ahb(1'b1, adcism_pkg::H_IRQ_EN, 32'h7);
    ahb(1'b0, adcism_pkg::H_IRQ_ST, 32'h0);
    `CHK("irq_clear", {32'h0, 1'b0}, {q, irq});
    cmd((32'h1 << adcism_pkg::CMD_SEL) | (32'h7 << adcism_pkg::CMD_CODE));
    ahb(1'b0, adcism_pkg::H_IRQ_ST, 32'h0);
    `CHK("bad_code", 2'h3, {q[adcism_pkg::IRQ_BAD], irq});
    ahb(1'b1, adcism_pkg::H_IRQ_CL, 32'h7);
    ahb(1'b1, adcism_pkg::H_IRQ_EN, 32'h1 << adcism_pkg::IRQ_DONE);
    ahb(1'b1, adcism_pkg::H_CTRL, 32'h1);
    m = 8'($urandom_range(255, 1));
    pulse(m, 1'b0, 1'b0);
    n = 0;
    do ahb(1'b0, adcism_pkg::H_IRQ_ST, 32'h0); while (q[adcism_pkg::IRQ_ALM] !== 1'b1 && ++n < 40);
    `CHK("alarm_masked", 2'h2, {q[adcism_pkg::IRQ_ALM], irq});
    ahb(1'b1, adcism_pkg::H_IRQ_EN, 32'h7);
    ahb(1'b0, adcism_pkg::H_STAT, 32'h0);
    `CHK("poll_flags", {m, 1'b1}, {q[15:8], irq});
    ahb(1'b1, adcism_pkg::H_CTRL, 32'h0);
    cmd(32'h0);
    ahb(1'b1, adcism_pkg::H_IRQ_CL, 32'h7);
    #1;
    `CHK("irq_off", {1'b0, 1'b0}, {irq, summary_flag});
    close_out();
  end
endmodule : testbench
